/* File: hdl/oabtu_consts.vh */
// Constants for the operand address and branch target unit
`ifndef OABTU_CONSTS_VH
`define OABTU_CONSTS_VH
// Addressing mode codes
`define OABTU_MODE_W        3
`define OABTU_MODE_IMM8     3'h0
`define OABTU_MODE_IMM16    3'h1
`define OABTU_MODE_DIR      3'h2
`define OABTU_MODE_EXT      3'h3
`define OABTU_MODE_REL      3'h4
// Branch kinds
`define OABTU_BR_W          3
`define OABTU_BR_SHORT      3'h0
`define OABTU_BR_LONG       3'h1
`define OABTU_BR_LOOP       3'h2
`define OABTU_BR_BSET       3'h3
`define OABTU_BR_BCLR       3'h4
// Widths and constants
`define OABTU_ADDR_W        16
`define OABTU_PAGE_ZERO     8'h00
`define OABTU_ZERO16        16'h0000
`define OABTU_ONE16         16'h0001
`define OABTU_TWO16         16'h0002
`define OABTU_FOUR16        16'h0004
// Opcodes for decode (generic table, values arbitrary)
`define OABTU_OP_PREBYTE    8'h18
`define OABTU_OP_BRA        8'h20
`define OABTU_OP_BRANCH_IF_BITS_SET      8'h1E
`define OABTU_OP_BRANCH_IF_BITS_CLEAR      8'h1F
`define OABTU_OP_LOOP       8'h04
`define OABTU_OP_LDX_IMM    8'hCE
`define OABTU_OP_LDX_DIR    8'hDE
`define OABTU_OP_LDX_EXT    8'hFE
`define OABTU_OP_LDA_IMM    8'h86
`define OABTU_OP_LDA_DIR    8'h96
`define OABTU_OP_LDA_EXT    8'hB6
// Queue depth in bytes
`define OABTU_Q_DEPTH       4
`define OABTU_Q_CNT_W       3
`endif

/* File: hdl/oabtu_queue.v */
// Instruction prefetch queue fed one 16-bit word per fetch
`timescale 1ns/1ns
`include "oabtu_consts.vh"
module oabtu_queue (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        flush,
  input  wire [15:0] flush_pc,
  input  wire        fetch_ack,
  input  wire [15:0] fetch_data,
  output wire        fetch_req,
  output reg  [15:0] fetch_addr_q,
  input  wire [2:0]  consume,
  output wire [2:0]  count,
  output wire [7:0]  byte0,
  output wire [7:0]  byte1,
  output wire [7:0]  byte2,
  output wire [7:0]  byte3
);
  reg [7:0] mem_q [0:`OABTU_Q_DEPTH-1];
  reg [2:0] cnt_q;
  integer   i;
  wire [2:0] left;
  wire       fill;

  assign left  = cnt_q - consume;
  // Fetch ahead whenever two bytes of room exist
  assign fetch_req = (cnt_q <= 3'h2) && !flush;
  assign fill      = fetch_req && fetch_ack;
  assign count = cnt_q;
  assign byte0 = mem_q[0];
  assign byte1 = mem_q[1];
  assign byte2 = mem_q[2];
  assign byte3 = mem_q[3];

  // Shift out consumed bytes, append one word per fetch
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_q        <= 3'h0;
      fetch_addr_q <= `OABTU_ZERO16;
      for (i = 0; i < `OABTU_Q_DEPTH; i = i + 1) begin
        mem_q[i] <= 8'h00;
      end
    end else if (clk_en) begin
      if (flush) begin
        cnt_q        <= 3'h0;
        fetch_addr_q <= flush_pc;
      end else begin
        for (i = 0; i < `OABTU_Q_DEPTH; i = i + 1) begin
          if (i + consume < `OABTU_Q_DEPTH) begin
            mem_q[i] <= mem_q[i + consume];
          end
        end
        if (fill) begin
          // High byte at the lower address
          mem_q[left[1:0]]        <= fetch_data[15:8];
          mem_q[left[1:0] + 2'h1] <= fetch_data[7:0];
          fetch_addr_q <= fetch_addr_q + `OABTU_TWO16;
        end
        cnt_q <= fill ? left + 3'h2 : left;
      end
    end
  end
endmodule

/* File: hdl/oabtu_target.v */
// Relative branch target adder with sign extension per branch kind
`timescale 1ns/1ns
`include "oabtu_consts.vh"
module oabtu_target (
  input  wire [2:0]  br_kind,
  input  wire [15:0] next_pc,
  input  wire [15:0] disp_raw,
  input  wire        loop_sign,
  output reg  [15:0] target
);
  reg [15:0] disp;

  // Widen the offset from its encoded width
  always @* begin
    disp = `OABTU_ZERO16;
    case (br_kind)
      `OABTU_BR_LONG: disp = disp_raw;
      `OABTU_BR_LOOP: disp = {{7{loop_sign}}, loop_sign, disp_raw[7:0]};
      default:        disp = {{8{disp_raw[7]}}, disp_raw[7:0]};
    endcase
    // Sum truncates to 16 bits so it wraps
    target = next_pc + disp;
  end
endmodule

/* File: hdl/oabtu_core.v */
// Operand address and branch target unit top
`timescale 1ns/1ns
`include "oabtu_consts.vh"
module oabtu_core (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        clk_en,
  input  wire        start_pc_load,
  input  wire [15:0] start_pc,
  output wire        fetch_req,
  output wire [15:0] fetch_addr,
  input  wire        fetch_ack,
  input  wire [15:0] fetch_data,
  input  wire        cond_met,
  input  wire        loop_met,
  output reg         mem_rd_q,
  output reg  [15:0] mem_addr_q,
  input  wire        mem_ack,
  input  wire [7:0]  mem_data,
  output reg         ex_valid_q,
  output reg  [2:0]  ex_mode_q,
  output reg  [15:0] ex_addr_q,
  output reg  [15:0] ex_operand_q,
  output reg         ex_taken_q,
  output reg  [15:0] pc_q
);
  localparam ST_DECODE = 2'h0;
  localparam ST_MEM_HI = 2'h1;
  localparam ST_MEM_LO = 2'h2;
  localparam ST_BITTST = 2'h3;

  reg  [1:0]  state_q;
  reg  [15:0] hold_q;
  reg  [7:0]  mask_q;
  reg  [7:0]  bdisp_q;
  reg  [15:0] bnext_q;
  reg         bclr_q;
  reg  [15:0] wide_q;
  wire [2:0]  qcount;
  wire [7:0]  b0;
  wire [7:0]  b1;
  wire [7:0]  b2;
  wire [7:0]  b3;
  reg  [2:0]  consume;
  reg  [2:0]  ilen;
  reg  [2:0]  mode;
  reg  [2:0]  br_kind;
  reg         is_word;
  reg         is_branch;
  reg  [15:0] disp_raw;
  wire [15:0] target;
  wire [15:0] next_pc;
  reg         flush;
  reg  [15:0] flush_pc;
  wire        bit_hit;
  wire [15:0] bit_tgt;
  wire        rel_take;

  // Length of instruction in bytes from the opcode alone
  function [2:0] op_len;
    input [7:0] op;
    begin
      case (op)
        `OABTU_OP_LDX_IMM: op_len = 3'h3;
        `OABTU_OP_LDX_EXT: op_len = 3'h3;
        `OABTU_OP_LDA_EXT: op_len = 3'h3;
        `OABTU_OP_PREBYTE: op_len = 3'h4;
        `OABTU_OP_BRANCH_IF_BITS_SET:   op_len = 3'h5;
        `OABTU_OP_BRANCH_IF_BITS_CLEAR:   op_len = 3'h5;
        `OABTU_OP_LOOP:    op_len = 3'h3;
        default:           op_len = 3'h2;
      endcase
    end
  endfunction

  oabtu_queue u_queue (
    .ref_clk      (ref_clk),
    .rstn         (rstn),
    .clk_en       (clk_en),
    .flush        (flush),
    .flush_pc     (flush_pc),
    .fetch_ack    (fetch_ack),
    .fetch_data   (fetch_data),
    .fetch_req    (fetch_req),
    .fetch_addr_q (fetch_addr),
    .consume      (consume),
    .count        (qcount),
    .byte0        (b0),
    .byte1        (b1),
    .byte2        (b2),
    .byte3        (b3)
  );

  assign next_pc = pc_q + {13'h0000, ilen};
  // Branch outcomes, needed early so a taken branch refills the queue
  assign bit_hit  = bclr_q ? ((mem_data & mask_q) == 8'h00) : ((mem_data & mask_q) == mask_q);
  assign bit_tgt  = bnext_q + {{8{b0[7]}}, b0};
  assign rel_take = (br_kind == `OABTU_BR_LOOP) ? loop_met : cond_met;

  oabtu_target u_target (
    .br_kind   (br_kind),
    .next_pc   (state_q == ST_BITTST ? bnext_q : next_pc),
    .disp_raw  (state_q == ST_BITTST ? {8'h00, bdisp_q} : disp_raw),
    .loop_sign (b1[4]),
    .target    (target)
  );

  // Decode the head of the queue into mode and length
  always @* begin
    ilen      = op_len(b0);
    is_word   = 1'b0;
    is_branch = 1'b0;
    mode      = `OABTU_MODE_IMM8;
    br_kind   = `OABTU_BR_SHORT;
    disp_raw  = {8'h00, b1};
    case (b0)
      `OABTU_OP_LDX_IMM: begin
        mode    = `OABTU_MODE_IMM16;
        is_word = 1'b1;
      end
      `OABTU_OP_LDX_DIR: begin
        mode    = `OABTU_MODE_DIR;
        is_word = 1'b1;
      end
      `OABTU_OP_LDX_EXT: begin
        mode    = `OABTU_MODE_EXT;
        is_word = 1'b1;
      end
      `OABTU_OP_LDA_DIR: mode = `OABTU_MODE_DIR;
      `OABTU_OP_LDA_EXT: mode = `OABTU_MODE_EXT;
      `OABTU_OP_PREBYTE: begin
        mode      = `OABTU_MODE_REL;
        is_branch = 1'b1;
        br_kind   = `OABTU_BR_LONG;
        disp_raw  = {b2, b3};
      end
      `OABTU_OP_LOOP: begin
        mode      = `OABTU_MODE_REL;
        is_branch = 1'b1;
        br_kind   = `OABTU_BR_LOOP;
        disp_raw  = {8'h00, b2};
      end
      `OABTU_OP_BRANCH_IF_BITS_SET: begin
        mode    = `OABTU_MODE_EXT;
        br_kind = `OABTU_BR_BSET;
      end
      `OABTU_OP_BRANCH_IF_BITS_CLEAR: begin
        mode    = `OABTU_MODE_EXT;
        br_kind = `OABTU_BR_BCLR;
      end
      default: begin
        // Remaining opcodes of the branch row are short branches
        if (b0[7:4] == `OABTU_OP_BRA >> 4) begin
          mode      = `OABTU_MODE_REL;
          is_branch = 1'b1;
        end
      end
    endcase
  end

  // Bytes dequeued this cycle, once the whole instruction is present or a bit branch fills the queue
  always @* begin
    consume  = 3'h0;
    flush    = start_pc_load;
    flush_pc = start_pc;
    if (clk_en && !start_pc_load && state_q == ST_DECODE && qcount >= ilen
        && qcount <= 3'h4 && ilen <= 3'h4) begin
      consume = ilen;
    end
    // Bit branch longer than queue: consume in two steps
    if (clk_en && !start_pc_load && state_q == ST_DECODE && ilen == 3'h5
        && qcount == 3'h4) begin
      consume = 3'h4;
    end
    // Taken branch redirects fetch; stale fall-through bytes are dropped
    if (clk_en && !start_pc_load && state_q == ST_DECODE && consume != 3'h0
        && mode == `OABTU_MODE_REL && rel_take) begin
      flush    = 1'b1;
      flush_pc = target;
    end
    // Offset byte of a bit branch leaves the queue when the test resolves
    if (clk_en && !start_pc_load && state_q == ST_BITTST && mem_rd_q && mem_ack) begin
      consume = 3'h1;
      if (bit_hit) begin
        flush    = 1'b1;
        flush_pc = bit_tgt;
      end
    end
  end

  // Sequencing of operand fetch and branch resolution
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q      <= ST_DECODE;
      pc_q         <= `OABTU_ZERO16;
      mem_rd_q     <= 1'b0;
      mem_addr_q   <= `OABTU_ZERO16;
      ex_valid_q   <= 1'b0;
      ex_mode_q    <= `OABTU_MODE_IMM8;
      ex_addr_q    <= `OABTU_ZERO16;
      ex_operand_q <= `OABTU_ZERO16;
      ex_taken_q   <= 1'b0;
      hold_q       <= `OABTU_ZERO16;
      mask_q       <= 8'h00;
      bdisp_q      <= 8'h00;
      bnext_q      <= `OABTU_ZERO16;
      bclr_q       <= 1'b0;
      wide_q       <= `OABTU_ZERO16;
    end else if (clk_en) begin
      ex_valid_q <= 1'b0;
      if (start_pc_load) begin
        pc_q     <= start_pc;
        mem_rd_q <= 1'b0;
        state_q  <= ST_DECODE;
      end else begin
        case (state_q)
          ST_DECODE: begin
            if (consume == 3'h4 && ilen == 3'h5) begin
              // Extended address and mask of a bit branch
              mem_addr_q <= {b1, b2};
              mask_q     <= b3;
              bnext_q    <= pc_q + 16'h0005;
              bclr_q     <= (br_kind == `OABTU_BR_BCLR);
              state_q    <= ST_BITTST;
            end else if (consume != 3'h0) begin
              ex_mode_q  <= mode;
              ex_taken_q <= 1'b0;
              pc_q       <= next_pc;
              case (mode)
                `OABTU_MODE_IMM16: begin
                  ex_operand_q <= {b1, b2};
                  ex_valid_q   <= 1'b1;
                end
                `OABTU_MODE_DIR: begin
                  mem_addr_q <= {`OABTU_PAGE_ZERO, b1};
                  mem_rd_q   <= 1'b1;
                  wide_q[0]  <= is_word;
                  state_q    <= ST_MEM_HI;
                end
                `OABTU_MODE_EXT: begin
                  mem_addr_q <= {b1, b2};
                  mem_rd_q   <= 1'b1;
                  wide_q[0]  <= is_word;
                  state_q    <= ST_MEM_HI;
                end
                `OABTU_MODE_REL: begin
                  // Only branches reach relative mode
                  ex_addr_q  <= target;
                  ex_valid_q <= 1'b1;
                  if ((br_kind == `OABTU_BR_LOOP) ? loop_met : cond_met) begin
                    // Taken target; zero offset equals next_pc
                    pc_q       <= target;
                    ex_taken_q <= 1'b1;
                  end
                end
                default: begin
                  ex_operand_q <= {8'h00, b1};
                  ex_valid_q   <= 1'b1;
                end
              endcase
            end
          end
          ST_MEM_HI: begin
            if (mem_ack) begin
              if (wide_q[0]) begin
                // First byte is the upper half
                hold_q     <= {mem_data, 8'h00};
                mem_addr_q <= mem_addr_q + `OABTU_ONE16;
                state_q    <= ST_MEM_LO;
              end else begin
                mem_rd_q     <= 1'b0;
                ex_addr_q    <= mem_addr_q;
                ex_operand_q <= {8'h00, mem_data};
                ex_valid_q   <= 1'b1;
                state_q      <= ST_DECODE;
              end
            end
          end
          ST_MEM_LO: begin
            if (mem_ack) begin
              mem_rd_q     <= 1'b0;
              ex_addr_q    <= mem_addr_q - `OABTU_ONE16;
              ex_operand_q <= {hold_q[15:8], mem_data};
              ex_valid_q   <= 1'b1;
              state_q      <= ST_DECODE;
            end
          end
          ST_BITTST: begin
            // Offset byte is head of queue; read memory byte
            // Read starts only once the offset byte is queued, so one ack resolves it
            if (!mem_rd_q) begin
              mem_rd_q <= (qcount != 3'h0);
            end else if (mem_ack) begin
              mem_rd_q   <= 1'b0;
              bdisp_q    <= b0;
              ex_mode_q  <= `OABTU_MODE_REL;
              ex_valid_q <= 1'b1;
              ex_addr_q  <= bnext_q + {{8{b0[7]}}, b0};
              if (bclr_q ? ((mem_data & mask_q) == 8'h00)
                         : ((mem_data & mask_q) == mask_q)) begin
                pc_q       <= bnext_q + {{8{b0[7]}}, b0};
                ex_taken_q <= 1'b1;
              end else begin
                pc_q       <= bnext_q;
                ex_taken_q <= 1'b0;
              end
              state_q <= ST_DECODE;
            end
          end
          default: state_q <= ST_DECODE;
        endcase
      end
    end
  end
endmodule

/* File: dv/oabtu_core_props.sv */
// Port-level assertions for the operand address and branch target core
`timescale 1ns/1ns
`include "oabtu_consts.vh"
module oabtu_core_props (
  input wire        ref_clk,
  input wire        rstn,
  input wire        clk_en,
  input wire        start_pc_load,
  input wire        fetch_req,
  input wire        mem_rd_q,
  input wire [15:0] mem_addr_q,
  input wire        mem_ack,
  input wire        ex_valid_q,
  input wire [2:0]  ex_mode_q,
  input wire [15:0] ex_addr_q,
  input wire        ex_taken_q,
  input wire [15:0] pc_q
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  // Steps of a data read and of a branch result
  sequence rd_done;
    mem_rd_q && mem_ack;
  endsequence
  sequence rd_again;
    mem_rd_q;
  endsequence
  sequence rel_result;
    ex_valid_q && ex_mode_q == `OABTU_MODE_REL;
  endsequence

  // Results and handshakes, each tied to its cause
  a_reset_clear: assert property ($rose(rstn) |-> !ex_valid_q && !mem_rd_q && pc_q == 16'h0000)
    else $error("outputs not clear after reset");
  a_fetch_after_load: assert property (start_pc_load |=> ##[0:3] fetch_req)
    else $error("no fetch after pc load");
  a_imm_no_read: assert property (ex_valid_q && ex_mode_q <= `OABTU_MODE_IMM16 |-> !mem_rd_q)
    else $error("immediate result while data read pending");
  a_mode_legal: assert property (ex_valid_q |-> ex_mode_q <= `OABTU_MODE_REL)
    else $error("result carries unknown mode");
  a_dir_page_zero: assert property (ex_valid_q && ex_mode_q == `OABTU_MODE_DIR |->
    ex_addr_q[15:8] == 8'h00) else $error("direct address left page zero");
  a_word_next_byte: assert property (rd_done ##1 rd_again |->
    mem_addr_q == $past(mem_addr_q) + 16'h0001) else $error("second byte not at next address");
  a_ext_read_addr: assert property (ex_valid_q && ex_mode_q == `OABTU_MODE_EXT |->
    mem_addr_q == ex_addr_q || mem_addr_q == ex_addr_q + 16'h0001)
    else $error("extended read address differs from result");
  a_rel_taken_pc: assert property (rel_result ##0 ex_taken_q |-> pc_q == ex_addr_q)
    else $error("taken branch did not move pc to target");
  a_rd_holds: assert property (mem_rd_q && !mem_ack && !start_pc_load |=>
    mem_rd_q && $stable(mem_addr_q))
    else $error("read request dropped before ack");
  a_freeze_hold: assert property (!clk_en |=> $stable(pc_q) && $stable(ex_valid_q))
    else $error("state moved while clock enable low");
endmodule

bind oabtu_core oabtu_core_props props_u (
  .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .start_pc_load(start_pc_load),
  .fetch_req(fetch_req), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
  .ex_valid_q(ex_valid_q), .ex_mode_q(ex_mode_q), .ex_addr_q(ex_addr_q),
  .ex_taken_q(ex_taken_q), .pc_q(pc_q)
);

/* File: dv/oabtu_mem_model.sv */
// Program fetch and data bus model standing behind the core
`timescale 1ns/1ns
module oabtu_mem_model (
  input  wire        ref_clk,
  input  wire        rstn,
  input  wire        slow,
  input  wire        fetch_req,
  input  wire [15:0] fetch_addr,
  output reg         fetch_ack,
  output reg  [15:0] fetch_data,
  input  wire        mem_rd_q,
  input  wire [15:0] mem_addr_q,
  output reg         mem_ack,
  output reg  [7:0]  mem_data
);
  reg [7:0] mem [0:65535];
  reg [1:0] f_wait_q;
  reg [1:0] m_wait_q;
  integer   i;

  // Zero filler decodes as short immediates, so stray fetches stay harmless
  initial begin
    for (i = 0; i < 65536; i = i + 1)
      mem[i] = 8'h00;
    fetch_ack = 1'b0;
    fetch_data = 16'h0000;
    mem_ack = 1'b0;
    mem_data = 8'h00;
    f_wait_q = 2'h0;
    m_wait_q = 2'h0;
  end

  // Answers move at the falling edge; idle buses show inverted data
  always @(negedge ref_clk) begin
    if (rstn && fetch_req && f_wait_q == (slow ? 2'h2 : 2'h0)) begin
      fetch_ack <= 1'b1;
      fetch_data <= {mem[fetch_addr], mem[fetch_addr + 16'h0001]};
      f_wait_q <= 2'h0;
    end else begin
      fetch_ack <= 1'b0;
      fetch_data <= ~fetch_data;
      f_wait_q <= fetch_req ? f_wait_q + 2'h1 : 2'h0;
    end
    if (rstn && mem_rd_q && !mem_ack && m_wait_q == (slow ? 2'h2 : 2'h0)) begin
      mem_ack <= 1'b1;
      mem_data <= mem[mem_addr_q];
      m_wait_q <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_data <= ~mem_data;
      m_wait_q <= (mem_rd_q && !mem_ack) ? m_wait_q + 2'h1 : 2'h0;
    end
  end
endmodule

/* File: dv/oabtu_core_tb_top.sv */
// Self-checking bench for the operand address and branch target core
`timescale 1ns/1ns
`include "oabtu_consts.vh"
module oabtu_core_tb_top;
  reg         ref_clk;
  reg         rstn;
  reg         clk_en;
  reg         start_pc_load;
  reg  [15:0] start_pc;
  reg         cond_met;
  reg         loop_met;
  reg         slow;
  wire        fetch_req;
  wire [15:0] fetch_addr;
  wire        fetch_ack;
  wire [15:0] fetch_data;
  wire        mem_rd_q;
  wire [15:0] mem_addr_q;
  wire        mem_ack;
  wire [7:0]  mem_data;
  wire        ex_valid_q;
  wire [2:0]  ex_mode_q;
  wire [15:0] ex_addr_q;
  wire [15:0] ex_operand_q;
  wire        ex_taken_q;
  wire [15:0] pc_q;
  integer     failures;
  integer     checked;

  oabtu_core dut_u (
    .ref_clk(ref_clk), .rstn(rstn), .clk_en(clk_en), .start_pc_load(start_pc_load),
    .start_pc(start_pc), .fetch_req(fetch_req), .fetch_addr(fetch_addr),
    .fetch_ack(fetch_ack), .fetch_data(fetch_data), .cond_met(cond_met),
    .loop_met(loop_met), .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack),
    .mem_data(mem_data), .ex_valid_q(ex_valid_q), .ex_mode_q(ex_mode_q),
    .ex_addr_q(ex_addr_q), .ex_operand_q(ex_operand_q), .ex_taken_q(ex_taken_q), .pc_q(pc_q)
  );
  oabtu_mem_model mdl_u (
    .ref_clk(ref_clk), .rstn(rstn), .slow(slow), .fetch_req(fetch_req),
    .fetch_addr(fetch_addr), .fetch_ack(fetch_ack), .fetch_data(fetch_data),
    .mem_rd_q(mem_rd_q), .mem_addr_q(mem_addr_q), .mem_ack(mem_ack), .mem_data(mem_data)
  );

  // Core clock, 8 ns period
  always #4 ref_clk = ~ref_clk;

  task chk(input [15:0] seen, input [15:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("ERROR at %0t: saw %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task tally_and_finish;
    begin
      $display("Comparisons %0d, mismatches %0d", checked, failures);
      if (failures == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask

  // Bounded wait for the next result pulse, sampled after the edge settles
  task wait_valid;
    integer n;
    begin
      n = 0;
      @(posedge ref_clk);
      #1;
      while (ex_valid_q !== 1'b1 && n < 100) begin
        @(posedge ref_clk);
        #1;
        n = n + 1;
      end
      if (n == 100)
        chk(16'h0001, 16'h0000);
    end
  endtask

  // Six program bytes, first byte in the top of code, then a pc load
  task run(input [15:0] pc, input [47:0] code);
    integer i;
    begin
      for (i = 0; i < 6; i = i + 1)
        mdl_u.mem[pc + i] = code[47 - 8 * i -: 8];
      @(negedge ref_clk);
      start_pc = pc;
      start_pc_load = 1'b1;
      @(negedge ref_clk);
      start_pc_load = 1'b0;
      wait_valid;
    end
  endtask

  task br(input [15:0] pc, input [47:0] code, input c, input [15:0] exp);
    begin
      cond_met = c;
      loop_met = c;
      run(pc, code);
      chk({13'h0, ex_mode_q}, {13'h0, `OABTU_MODE_REL});
      chk(pc_q, exp);
    end
  endtask

  task s_imm;
    begin
      run(16'h0100, 48'hCE1234865500);
      chk({13'h0, ex_mode_q}, {13'h0, `OABTU_MODE_IMM16});
      chk(ex_operand_q, 16'h1234);
      wait_valid;
      chk({13'h0, ex_mode_q}, {13'h0, `OABTU_MODE_IMM8});
      chk({8'h00, ex_operand_q[7:0]}, 16'h0055);
    end
  endtask

  // Data reads with the far side stalling
  task s_mem;
    begin
      slow = 1'b1;
      mdl_u.mem[16'h0020] = 8'hA1;
      mdl_u.mem[16'h0021] = 8'hB2;
      mdl_u.mem[16'hF03B] = 8'hC3;
      mdl_u.mem[16'hF03C] = 8'hD4;
      run(16'h0200, 48'hDE20FEF03B00);
      chk({13'h0, ex_mode_q}, {13'h0, `OABTU_MODE_DIR});
      chk(ex_addr_q, 16'h0020);
      chk(ex_operand_q, 16'hA1B2);
      wait_valid;
      chk(ex_addr_q, 16'hF03B);
      chk(ex_operand_q, 16'hC3D4);
      run(16'h0240, 48'hB6F03B000000);
      chk({8'h00, ex_operand_q[7:0]}, 16'h00C3);
      slow = 1'b0;
    end
  endtask

  task s_short;
    begin
      br(16'h1000, 48'h267F00000000, 1'b1, 16'h1081);
      br(16'h1000, 48'h268000000000, 1'b1, 16'h0F82);
      br(16'h1000, 48'h267F00000000, 1'b0, 16'h1002);
      br(16'h1000, 48'h260000000000, 1'b1, 16'h1002);
      br(16'h1000, 48'h200000000000, 1'b0, 16'h1002);
      br(16'h1000, 48'h20FE00000000, 1'b1, 16'h1000);
      br(16'hFFF0, 48'h267F00000000, 1'b1, 16'h0071);
    end
  endtask

  task s_long;
    begin
      br(16'h2000, 48'h18267FFF0000, 1'b1, 16'hA003);
      br(16'h2000, 48'h182680000000, 1'b1, 16'hA004);
      br(16'h2000, 48'h1820FFFC0000, 1'b1, 16'h2000);
      br(16'h2000, 48'h18267FFF0000, 1'b0, 16'h2004);
    end
  endtask

  task s_loop;
    begin
      br(16'h3000, 48'h041000000000, 1'b1, 16'h2F03);
      br(16'h3000, 48'h0400FF000000, 1'b1, 16'h3102);
      br(16'h3000, 48'h0400FF000000, 1'b0, 16'h3003);
    end
  endtask

  // Bit tests against a stalled data bus
  task s_bits;
    begin
      slow = 1'b1;
      mdl_u.mem[16'hF040] = 8'h07;
      br(16'h4000, 48'h1EF040031000, 1'b0, 16'h4015);
      br(16'h4000, 48'h1EF04008F000, 1'b0, 16'h4005);
      br(16'h4000, 48'h1FF04008FB00, 1'b0, 16'h4000);
      br(16'h4000, 48'h1FF04001FB00, 1'b0, 16'h4005);
      slow = 1'b0;
    end
  endtask

  // Clock enable low must hold the program counter
  task s_freeze;
    reg [15:0] held;
    begin
      run(16'h5000, 48'h860186028603);
      @(negedge ref_clk);
      clk_en = 1'b0;
      held = pc_q;
      repeat (5) @(negedge ref_clk);
      chk(pc_q, held);
      clk_en = 1'b1;
    end
  endtask

  // Reset for ten cycles, then every scenario in turn
  initial begin
    ref_clk = 1'b0;
    rstn = 1'b0;
    clk_en = 1'b1;
    start_pc_load = 1'b0;
    start_pc = 16'h0000;
    cond_met = 1'b0;
    loop_met = 1'b0;
    slow = 1'b0;
    failures = 0;
    checked = 0;
    repeat (10) @(negedge ref_clk);
    rstn = 1'b1;
    s_imm;
    s_mem;
    s_short;
    s_long;
    s_loop;
    s_bits;
    s_freeze;
    tally_and_finish;
  end

  // Watchdog far beyond the few hundred cycles the scenarios need
  initial begin
    #400000;
    failures = failures + 1;
    tally_and_finish;
  end
endmodule
